// [shared/odwd_pkg.sv]
// Shared constants and types of the output drum word decoder
package odwd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Drum word layout, parity sits above the left half
    typedef struct packed {
        logic parity;
        logic [2:0] sectionSel;
        logic [4:0] slotRegSel;
        logic [7:0] burstNum;
        logic [15:0] dataHalf;
    } odwd_word_t;

    localparam int WORD_BITS = 33;
    localparam int HALF_BITS = 16;
    localparam int SIGN_POS = 15;
    localparam int CORE_REGS = 26;
    localparam int NUM_SECTIONS = 3;

    // Section selector codes, all zeros is illegal
    localparam logic [2:0] SEC_ILLEGAL = 3'h0;
    localparam logic [2:0] SEC_GA = 3'h1;
    localparam logic [2:0] SEC_GG = 3'h2;
    localparam logic [2:0] SEC_TTY = 3'h3;
    localparam logic [1:0] IDX_GG = 2'h0;
    localparam logic [1:0] IDX_GA = 2'h1;
    localparam logic [1:0] IDX_TTY = 2'h2;
    localparam logic [1:0] IDX_NONE = 2'h3;

    // Registers per slot and registers in use per section
    localparam logic [4:0] GG_SLOT_REGS = 5'h5;
    localparam logic [4:0] GA_SLOT_REGS = 5'h4;
    localparam logic [4:0] TTY_SLOT_REGS = 5'h1;
    localparam logic [4:0] GG_USED_REGS = 5'h19;
    localparam logic [4:0] GA_USED_REGS = 5'h18;
    localparam logic [4:0] TTY_USED_REGS = 5'h19;
    localparam logic [4:0] TTY_MONITOR_LINE = 5'h18;

    // Burst counter spans
    localparam int GG_BURST_BITS = 8;
    localparam int TTY_BURST_BITS = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: 100 MHz clock, burst periods in seconds as fractions
    localparam longint CLK_HZ = 64'd100_000_000;
    localparam longint GG_PERIOD_NUM_S = 64'd92;
    localparam longint GG_PERIOD_DEN_S = 64'd1300;
    localparam longint TTY_PERIOD_NUM_S = 64'd45;
    localparam longint TTY_PERIOD_DEN_S = 64'd91;
    localparam longint GG_PERIOD_CYCLES = CLK_HZ * GG_PERIOD_NUM_S / GG_PERIOD_DEN_S;
    localparam longint TTY_PERIOD_CYCLES = CLK_HZ * TTY_PERIOD_NUM_S / TTY_PERIOD_DEN_S;
    localparam int PHASE_COUNT = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Verdict for one word, each bit a one-cycle pulse
    typedef struct packed {
        logic accepted;
        logic parityError;
        logic tooEarly;
        logic illegal;
        logic freeBuffer;
    } odwd_verdict_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BURST = 8'h04;
    localparam logic [7:0] OFF_ACCEPT_CNT = 8'h08;
    localparam logic [7:0] OFF_PARITY_CNT = 8'h0c;
    localparam logic [7:0] OFF_EARLY_CNT = 8'h10;
    localparam logic [7:0] OFF_ILLEGAL_CNT = 8'h14;
    localparam logic [7:0] OFF_PEEK_SEL = 8'h18;
    localparam logic [7:0] OFF_PEEK_DATA = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_BURST_CLEAR = 1;
    localparam int STATUS_PHASE_ERR = 0;
    localparam int STATUS_OVERRUN = 1;
    localparam int BURST_TTY_POS = 16;
    localparam int PEEK_SEC_POS = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HELD = 2'b01,
        ST_DONE = 2'b10
    } odwd_stage_t;

endpackage

// [sim/odwd_decoder_sva.sv]
// Checker for verdicts and line side of the decoder
module odwd_decoder_sva
    import odwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WORD_BITS-1:0] drumWord,
    input wire logic drumWordValid,
    input wire odwd_verdict_t verdict,
    input wire logic [1:0] lineSection,
    input wire logic [4:0] lineRegister,
    input wire logic [4:0] lineNumber,
    input wire logic lineSelfMonitor
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_verdict;
        verdict != 5'h00;
    endsequence
    sequence s_mon;
        lineSection == IDX_TTY && lineRegister == TTY_MONITOR_LINE;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_verdict_pulse: assert property (s_verdict |=> verdict == 5'h00)
        else $error("verdict longer than one cycle");
    chk_verdict_kind: assert property (s_verdict |-> $onehot({verdict.accepted,
        verdict.parityError, verdict.tooEarly, verdict.illegal}))
        else $error("verdict kind not unique");
    chk_buffer_free: assert property (s_verdict |-> verdict.freeBuffer == !verdict.tooEarly)
        else $error("buffer release wrong");
    chk_word_present: assert property (s_verdict |-> drumWordValid)
        else $error("verdict without word");
    chk_parity_odd: assert property (verdict.accepted |-> ^drumWord)
        else $error("even word accepted");
    chk_parity_even: assert property (verdict.parityError |-> !(^drumWord))
        else $error("odd word rejected");
    chk_section_zero: assert property (verdict.accepted |-> drumWord[31:29] != SEC_ILLEGAL)
        else $error("zero section accepted");
    chk_tty_sign: assert property (verdict.accepted && drumWord[31:29] == SEC_TTY
        |-> drumWord[SIGN_POS])
        else $error("teleprinter word without sign one");
    chk_self_mon: assert property (s_mon |=> lineSelfMonitor)
        else $error("monitor line not flagged");
    chk_mon_only: assert property (!(lineSection == IDX_TTY && lineRegister == TTY_MONITOR_LINE)
        |=> !lineSelfMonitor)
        else $error("monitor flag on other line");
    chk_gg_line: assert property (lineSection == IDX_GG && lineRegister < GG_USED_REGS
        |=> lineNumber == $past(lineRegister) / 5)
        else $error("ground line number wrong");
    chk_ga_line: assert property (lineSection == IDX_GA && lineRegister < GA_USED_REGS
        |=> lineNumber == {$past(lineRegister[4:2]), $past(lineRegister[1])})
        else $error("ground-air line number wrong");
    chk_tty_line: assert property (lineSection == IDX_TTY && lineRegister < TTY_USED_REGS
        |=> lineNumber == $past(lineRegister))
        else $error("teleprinter line number wrong");
endmodule
bind odwd_decoder odwd_decoder_sva i_sva (.clk(clk), .rst(rst), .drumWord(drumWord),
    .drumWordValid(drumWordValid), .verdict(verdict), .lineSection(lineSection),
    .lineRegister(lineRegister), .lineNumber(lineNumber), .lineSelfMonitor(lineSelfMonitor));

// [sim/odwd_drum_model.sv]
// Drum side model: timing phases and one buffer word per cycle
module odwd_drum_model
    import odwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WORD_BITS-1:0] txWord,
    input wire logic txValid,
    output logic taken,
    output logic [WORD_BITS-1:0] drumWord,
    output logic drumWordValid,
    output logic [PHASE_COUNT-1:0] drumPhase
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int GAP = 10;
    logic [5:0] cycCnt;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cycCnt <= 6'h00;
        else if (cycCnt == 6'(4 * GAP - 1)) cycCnt <= 6'h00;
        else cycCnt <= cycCnt + 6'h01;
    end
    // Phases 1 to 4 in fixed order, evenly spaced
    always_comb begin
        for (int k = 0; k < PHASE_COUNT; k++) begin
            drumPhase[k] = (cycCnt >= 6'(k * GAP)) && (cycCnt < 6'(k * GAP + 2));
        end
    end
    // One word per cycle, held all cycle; an empty slot shows a changing pattern
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drumWord <= '0;
            drumWordValid <= 1'b0;
            taken <= 1'b0;
        end else begin
            taken <= 1'b0;
            if (cycCnt == 6'(4 * GAP - 1)) begin
                taken <= txValid;
                drumWordValid <= txValid;
                drumWord <= txValid ? txWord : ~drumWord;
            end
        end
    end
endmodule

// [sim/tb_top.sv]
// Testbench for the output drum word decoder
module tb_top
    import odwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0] ACC = 5'h11;
    localparam logic [4:0] ILL = 5'h03;
    typedef struct packed {
        logic [2:0] sec;
        logic [4:0] rg;
        logic [7:0] bn;
        logic [15:0] dat;
        logic bad;
        logic [4:0] exp;
    } odwd_row_t;
    localparam odwd_row_t ROWS [8] = '{'{SEC_GG, 5'h07, 8'h00, 16'h1234, 1'b0, ACC},
        '{SEC_GA, 5'h05, 8'h00, 16'h5a5a, 1'b0, ACC}, '{SEC_TTY, 5'h18, 8'h00, 16'h9021, 1'b0, ACC},
        '{SEC_TTY, 5'h03, 8'h00, 16'h0421, 1'b0, ILL}, '{SEC_ILLEGAL, 5'h01, 8'h00, 16'h0001, 1'b0, ILL},
        '{SEC_GG, 5'h19, 8'h00, 16'h0002, 1'b0, ILL}, '{SEC_GG, 5'h02, 8'h00, 16'hffff, 1'b1, 5'h09},
        '{SEC_GA, 5'h01, 8'h01, 16'h0003, 1'b0, 5'h04}};
    localparam logic [7:0] CNT_OFF [4] = '{OFF_ACCEPT_CNT, OFF_PARITY_CNT, OFF_EARLY_CNT,
        OFF_ILLEGAL_CNT};
    localparam logic [31:0] CNT_EXP [4] = '{32'h8, 32'h1, 32'h1, 32'h3};
    logic clk, rst, hsel, hwrite, hreadyout, hresp, txValid, taken, drumWordValid;
    logic lineSelfMonitor;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, lineSection;
    logic [2:0] hsize;
    logic [WORD_BITS-1:0] txWord, drumWord;
    logic [PHASE_COUNT-1:0] drumPhase;
    odwd_verdict_t verdict;
    logic [4:0] lineRegister, lineNumber;
    logic [HALF_BITS-1:0] lineData;
    int miscompares = 0;
    int nCompared = 0;
    ////////////////////////////////////////////////////////////////////////////
    odwd_decoder #(.GG_BURST_CYCLES(250), .TTY_BURST_CYCLES(300)) i_dut (.clk(clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .drumWord(drumWord), .drumWordValid(drumWordValid),
        .drumPhase(drumPhase), .verdict(verdict), .lineSection(lineSection),
        .lineRegister(lineRegister), .lineData(lineData), .lineNumber(lineNumber),
        .lineSelfMonitor(lineSelfMonitor));
    odwd_drum_model i_drum (.clk(clk), .rst(rst), .txWord(txWord), .txValid(txValid),
        .taken(taken), .drumWord(drumWord), .drumWordValid(drumWordValid),
        .drumPhase(drumPhase));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic send(input logic [2:0] sec, input logic [4:0] rg, input logic [7:0] bn,
            input logic [15:0] dat, input logic bad, input logic clr, output logic [4:0] v);
        logic [31:0] body;
        logic [31:0] r;
        body = {sec, rg, bn, dat};
        if (clr) ahb(1'b1, OFF_CTRL, 32'h3, r);
        txWord <= {(~^body) ^ bad, body};
        txValid <= 1'b1;
        do @(posedge clk); while (taken !== 1'b1);
        txValid <= 1'b0;
        v = 5'h00;
        for (int i = 0; i < 60 && v === 5'h00; i++) begin
            @(posedge clk);
            v = verdict;
        end
    endtask
    task automatic line_chk(input logic [2:0] sec, input logic [4:0] rg, input logic [15:0] e);
        lineSection <= (sec == SEC_GG) ? IDX_GG : (sec == SEC_GA) ? IDX_GA : IDX_TTY;
        lineRegister <= rg;
        repeat (2) @(posedge clk);
        chk("lineData", {16'h0, lineData}, {16'h0, e});
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #900us;
        miscompares++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [4:0] v;
        rst = 1'b1;
        {hsel, hwrite, txValid, haddr, hwdata, htrans, txWord, lineRegister} = '0;
        hsize = 3'h2;
        lineSection = IDX_NONE;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("verdict", {27'h0, verdict}, 32'h0);
        ahb(1'b0, OFF_ACCEPT_CNT, 32'h0, r);
        chk("acceptCount", r, 32'h0);
        foreach (ROWS[i]) begin
            send(ROWS[i].sec, ROWS[i].rg, ROWS[i].bn, ROWS[i].dat, ROWS[i].bad, 1'b1, v);
            chk("verdict", {27'h0, v}, {27'h0, ROWS[i].exp});
            if (ROWS[i].exp == ACC) line_chk(ROWS[i].sec, ROWS[i].rg, ROWS[i].dat);
        end
        for (int k = 0; k < 5; k++) begin
            send(SEC_GA, 5'(k % 4), 8'h00, 16'h0c00 + 16'(k), 1'b0, k == 0, v);
            chk("messageVerdict", {27'h0, v}, {27'h0, ACC});
        end
        for (int k = 0; k < 4; k++) line_chk(SEC_GA, 5'(k), 16'h0c00 + 16'(k));
        ahb(1'b0, OFF_STATUS, 32'h0, r);
        chk("status", r, 32'h2);
        ahb(1'b1, OFF_STATUS, 32'h2, r);
        ahb(1'b0, OFF_STATUS, 32'h0, r);
        chk("status", r, 32'h0);
        foreach (CNT_OFF[i]) begin
            ahb(1'b0, CNT_OFF[i], 32'h0, r);
            chk("verdictCount", r, CNT_EXP[i]);
        end
        ahb(1'b0, 8'h40, 32'h0, r);
        chk("unmapped", r, 32'h0);
        ahb(1'b1, OFF_CTRL, 32'h0, r);
        send(SEC_GG, 5'h00, 8'h00, 16'h0007, 1'b0, 1'b0, v);
        chk("disabledVerdict", {27'h0, v}, 32'h0);
        ahb(1'b1, OFF_CTRL, 32'h3, r);
        repeat (63875) @(posedge clk);
        ahb(1'b0, OFF_BURST, 32'h0, r);
        chk("burstBeforeWrap", r, 32'h0014_00ff);
        repeat (248) @(posedge clk);
        ahb(1'b0, OFF_BURST, 32'h0, r);
        chk("burstAfterWrap", r, 32'h0015_0000);
        close_out();
    end
endmodule

// [verilog/odwd_decoder.sv]
// Output drum word decoder: parity check, routing into section core arrays
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
module odwd_decoder
    import odwd_pkg::*;
#(
    parameter int unsigned GG_BURST_CYCLES = 32'(GG_PERIOD_CYCLES),
    parameter int unsigned TTY_BURST_CYCLES = 32'(TTY_PERIOD_CYCLES)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [WORD_BITS-1:0] drumWord,
    input wire logic drumWordValid,
    input wire logic [PHASE_COUNT-1:0] drumPhase,
    output odwd_verdict_t verdict,
    input wire logic [1:0] lineSection,
    input wire logic [4:0] lineRegister,
    output logic [HALF_BITS-1:0] lineData,
    output logic [4:0] lineNumber,
    output logic lineSelfMonitor
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [WORD_BITS-1:0] wordMeta_reg;
    logic [WORD_BITS-1:0] wordSync_reg;
    logic validMeta_reg;
    logic validSync_reg;
    logic [PHASE_COUNT-1:0] phaseMeta_reg;
    logic [PHASE_COUNT-1:0] phaseSync_reg;
    logic [PHASE_COUNT-1:0] phaseLast_reg;
    logic [PHASE_COUNT-1:0] phaseEdge;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wordMeta_reg <= '0;
            wordSync_reg <= '0;
            validMeta_reg <= 1'b0;
            validSync_reg <= 1'b0;
            phaseMeta_reg <= '0;
            phaseSync_reg <= '0;
            phaseLast_reg <= '0;
        end else begin
            wordMeta_reg <= drumWord;
            wordSync_reg <= wordMeta_reg;
            validMeta_reg <= drumWordValid;
            validSync_reg <= validMeta_reg;
            phaseMeta_reg <= drumPhase;
            phaseSync_reg <= phaseMeta_reg;
            phaseLast_reg <= phaseSync_reg;
        end
    end

    assign phaseEdge = phaseSync_reg & ~phaseLast_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic enable_reg;
    logic burstClear_reg;
    logic phaseErr_reg;
    logic overrun_reg;
    logic [15:0] acceptCnt_reg;
    logic [15:0] parityCnt_reg;
    logic [15:0] earlyCnt_reg;
    logic [15:0] illegalCnt_reg;
    logic [1:0] peekSec_reg;
    logic [4:0] peekReg_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequence tracking
    logic [1:0] expectPhase_reg;
    logic phaseFault;
    logic [1:0] seenPhase;

    always_comb begin
        seenPhase = 2'h0;
        for (int i = 0; i < PHASE_COUNT; i++) begin
            if (phaseEdge[i]) begin
                seenPhase = 2'(i);
            end
        end
    end

    assign phaseFault = (|phaseEdge) && (seenPhase != expectPhase_reg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            expectPhase_reg <= 2'h0;
        end else if (|phaseEdge) begin
            expectPhase_reg <= seenPhase + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst counters
    logic [31:0] ggTimer_reg;
    logic [31:0] ttyTimer_reg;
    logic [GG_BURST_BITS-1:0] ggBurst_reg;
    logic [TTY_BURST_BITS-1:0] ttyBurst_reg;
    logic ggStep;
    logic ttyStep;

    assign ggStep = ggTimer_reg == GG_BURST_CYCLES - 32'd1;
    assign ttyStep = ttyTimer_reg == TTY_BURST_CYCLES - 32'd1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ggTimer_reg <= '0;
            ggBurst_reg <= '0;
        end else if (burstClear_reg) begin
            ggTimer_reg <= '0;
            ggBurst_reg <= '0;
        end else if (ggStep) begin
            ggTimer_reg <= '0;
            ggBurst_reg <= ggBurst_reg + 1'b1;
        end else begin
            ggTimer_reg <= ggTimer_reg + 32'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ttyTimer_reg <= '0;
            ttyBurst_reg <= '0;
        end else if (burstClear_reg) begin
            ttyTimer_reg <= '0;
            ttyBurst_reg <= '0;
        end else if (ttyStep) begin
            ttyTimer_reg <= '0;
            ttyBurst_reg <= ttyBurst_reg + 1'b1;
        end else begin
            ttyTimer_reg <= ttyTimer_reg + 32'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word capture at phase one, decision at phase two
    odwd_word_t held_reg;
    odwd_stage_t stage_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_reg <= '0;
            stage_reg <= ST_IDLE;
        end else begin
            case (stage_reg)
                ST_IDLE: begin
                    if (phaseEdge[0] && validSync_reg && enable_reg) begin
                        held_reg <= wordSync_reg;
                        stage_reg <= ST_HELD;
                    end
                end
                ST_HELD: begin
                    if (phaseEdge[1]) begin
                        stage_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    stage_reg <= ST_IDLE;
                end
                default: begin
                    stage_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Classification
    logic [1:0] secIdx;
    logic [4:0] usedRegs;
    logic parityOk;
    logic burstMatch;
    logic wordLegal;
    logic slotBusy;
    logic decide;
    logic writeCore;
    logic [CORE_REGS-1:0] full_reg [NUM_SECTIONS];

    always_comb begin
        secIdx = IDX_NONE;
        usedRegs = 5'h0;
        case (held_reg.sectionSel)
            SEC_GG: begin
                secIdx = IDX_GG;
                usedRegs = GG_USED_REGS;
            end
            SEC_GA: begin
                secIdx = IDX_GA;
                usedRegs = GA_USED_REGS;
            end
            SEC_TTY: begin
                secIdx = IDX_TTY;
                usedRegs = TTY_USED_REGS;
            end
            default: begin
                secIdx = IDX_NONE;
                usedRegs = 5'h0;
            end
        endcase
    end

    assign decide = (stage_reg == ST_HELD) && phaseEdge[1];
    assign parityOk = ^held_reg;
    assign burstMatch = (secIdx == IDX_TTY) ?
        (held_reg.burstNum == {3'h0, ttyBurst_reg}) :
        (held_reg.burstNum == ggBurst_reg);
    assign wordLegal = (secIdx != IDX_NONE) && (held_reg.slotRegSel < usedRegs) &&
        ((secIdx != IDX_TTY) || held_reg.dataHalf[SIGN_POS]);
    assign slotBusy = (secIdx != IDX_NONE) && (held_reg.slotRegSel < usedRegs) &&
        full_reg[secIdx][held_reg.slotRegSel];
    assign writeCore = decide && parityOk && wordLegal && burstMatch && !slotBusy;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            verdict <= '0;
        end else begin
            verdict <= '0;
            if (decide) begin
                verdict.parityError <= !parityOk;
                verdict.illegal <= parityOk && !wordLegal;
                verdict.tooEarly <= parityOk && wordLegal && !burstMatch;
                verdict.accepted <= parityOk && wordLegal && burstMatch;
                verdict.freeBuffer <= !parityOk || !wordLegal || burstMatch;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core arrays, occupancy cleared as each burst period ends unless that section is written in the same cycle
    logic [HALF_BITS-1:0] core_reg [NUM_SECTIONS][CORE_REGS];

    always_ff @(posedge clk) begin
        if (writeCore) begin
            core_reg[secIdx][held_reg.slotRegSel] <= held_reg.dataHalf;
        end
    end

    generate
        for (genvar s = 0; s < NUM_SECTIONS; s++) begin : gSection
            logic burstEnd;
            assign burstEnd = burstClear_reg || ((s == IDX_TTY) ? ttyStep : ggStep);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    full_reg[s] <= '0;
                end else if (writeCore && secIdx == 2'(s)) begin
                    full_reg[s][held_reg.slotRegSel] <= 1'b1;
                end else if (burstEnd) begin
                    full_reg[s] <= '0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Line side readout
    function automatic logic [4:0] lineOf(input logic [1:0] sec, input logic [4:0] r);
        logic [4:0] slot;
        slot = 5'h0;
        case (sec)
            IDX_GG: begin
                slot = r / GG_SLOT_REGS;
            end
            IDX_GA: begin
                slot = 5'({(r / GA_SLOT_REGS), 1'b0}) | {4'h0, r[1]};
            end
            default: begin
                slot = r / TTY_SLOT_REGS;
            end
        endcase
        return slot;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineData <= '0;
            lineNumber <= '0;
            lineSelfMonitor <= 1'b0;
        end else if (lineSection != IDX_NONE && lineRegister < 5'(CORE_REGS)) begin
            lineData <= core_reg[lineSection][lineRegister];
            lineNumber <= lineOf(lineSection, lineRegister);
            lineSelfMonitor <= (lineSection == IDX_TTY) && (lineRegister == TTY_MONITOR_LINE);
        end else begin
            lineData <= '0;
            lineNumber <= '0;
            lineSelfMonitor <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic addrPhase;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

    function automatic logic [31:0] readMux(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            OFF_CTRL: d[CTRL_ENABLE] = enable_reg;
            OFF_BURST: begin
                d[GG_BURST_BITS-1:0] = ggBurst_reg;
                d[BURST_TTY_POS +: TTY_BURST_BITS] = ttyBurst_reg;
            end
            OFF_ACCEPT_CNT: d[15:0] = acceptCnt_reg;
            OFF_PARITY_CNT: d[15:0] = parityCnt_reg;
            OFF_EARLY_CNT: d[15:0] = earlyCnt_reg;
            OFF_ILLEGAL_CNT: d[15:0] = illegalCnt_reg;
            OFF_PEEK_SEL: begin
                d[4:0] = peekReg_reg;
                d[PEEK_SEC_POS +: 2] = peekSec_reg;
            end
            OFF_PEEK_DATA: begin
                if (peekSec_reg != IDX_NONE && peekReg_reg < 5'(CORE_REGS)) begin
                    d[HALF_BITS-1:0] = core_reg[peekSec_reg][peekReg_reg];
                end
            end
            OFF_STATUS: begin
                d[STATUS_PHASE_ERR] = phaseErr_reg;
                d[STATUS_OVERRUN] = overrun_reg;
            end
            default: d = 32'h0;
        endcase
        return d;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= '0;
            wrPend_reg <= 1'b0;
            wrAddr_reg <= '0;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr_reg <= haddr[7:0];
            end
            if (addrPhase && !hwrite) begin
                hrdata <= readMux(haddr[7:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and hardware-set status
    logic wrCtrl;
    logic wrStatus;

    assign wrCtrl = wrPend_reg && wrAddr_reg == OFF_CTRL;
    assign wrStatus = wrPend_reg && wrAddr_reg == OFF_STATUS;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_reg <= 1'b0;
            burstClear_reg <= 1'b0;
            peekSec_reg <= '0;
            peekReg_reg <= '0;
        end else begin
            burstClear_reg <= wrCtrl && hwdata[CTRL_BURST_CLEAR];
            if (wrCtrl) begin
                enable_reg <= hwdata[CTRL_ENABLE];
            end
            if (wrPend_reg && wrAddr_reg == OFF_PEEK_SEL) begin
                peekReg_reg <= hwdata[4:0];
                peekSec_reg <= hwdata[PEEK_SEC_POS +: 2];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phaseErr_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            phaseErr_reg <= phaseFault ||
                (phaseErr_reg && !(wrStatus && hwdata[STATUS_PHASE_ERR]));
            overrun_reg <= (decide && slotBusy && parityOk && burstMatch) ||
                (overrun_reg && !(wrStatus && hwdata[STATUS_OVERRUN]));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acceptCnt_reg <= '0;
            parityCnt_reg <= '0;
            earlyCnt_reg <= '0;
            illegalCnt_reg <= '0;
        end else begin
            acceptCnt_reg <= acceptCnt_reg + {15'h0, verdict.accepted};
            parityCnt_reg <= parityCnt_reg + {15'h0, verdict.parityError};
            earlyCnt_reg <= earlyCnt_reg + {15'h0, verdict.tooEarly};
            illegalCnt_reg <= illegalCnt_reg + {15'h0, verdict.illegal};
        end
    end

endmodule
